// >>> design/framer_irq_and_link_select_regs.sv
`include "framer_irq_params.svh"

module framer_irq_and_link_select_regs
  import framer_irq_pkg::*;
#(
  parameter int NUM_EVENTS = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic [`ADDR_W-1:0]    avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [`DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [`DATA_W-1:0]    avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [NUM_EVENTS-1:0] framer_event,
  input  wire logic                  loss_of_signal,
  output logic                       irq,
  output logic      [2:0]            hdlc_ctrl_sel,
  output logic                       receive_loss_pin_n,
  output logic                       receive_loss_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  bus_state_type                 bus_state_ff;
  bus_state_type                 nxt_bus_state;
  logic                          bus_req;
  logic                          bus_accept;
  logic                          wr_accept;
  logic                          rd_accept;
  logic [`IDX_W-1:0]             word_idx;
  logic                          sel_status;
  logic                          sel_enable;
  logic                          sel_ctrl;
  logic                          sel_hdlc;
  logic                          sel_loss;
  logic [`DATA_W-1:0]            readdata_ff;
  logic [`DATA_W-1:0]            nxt_readdata;
  logic                          snap_status_ff;

  logic                          clr_mode_ff;
  logic                          auto_clr_ff;
  logic                          blk_en_ff;
  logic [`HSEL_MSB:`HSEL_LSB]    hsel_ff;
  logic                          loss_oe_ff;

  logic [NUM_EVENTS-1:0]         status_vec;
  logic [NUM_EVENTS-1:0]         enable_vec;
  logic [NUM_EVENTS-1:0]         status_clr_vec;
  logic [NUM_EVENTS-1:0]         enable_clr_vec;
  logic [NUM_EVENTS-1:0]         read_snap;
  logic                          enable_wr;

  logic                          irq_ff;
  logic [2:0]                    hdlc_sel_ff;
  logic                          loss_pin_n_ff;
  logic                          loss_pin_oe_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave handshake: one wait cycle, then accept

  assign bus_req  = avs_read | avs_write;
  assign word_idx = avs_address[`ADDR_W-1:2];

  always_comb begin
    nxt_bus_state = BUS_IDLE;
    unique case (bus_state_ff)
      BUS_IDLE: begin
        nxt_bus_state = bus_req ? BUS_ACK : BUS_IDLE;
      end
      BUS_ACK: begin
        nxt_bus_state = BUS_IDLE;
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_ff <= BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // waitrequest straight from the state flop, low only in the accept cycle
  assign avs_waitrequest = (bus_state_ff != BUS_ACK);
  assign bus_accept      = (bus_state_ff == BUS_ACK) & bus_req;
  assign wr_accept       = bus_accept & avs_write & avs_byteenable[0];
  assign rd_accept       = bus_accept & avs_read;
  assign sel_status      = (word_idx == `IDX_IRQ_STATUS);
  assign sel_enable      = (word_idx == `IDX_IRQ_ENABLE);
  assign sel_ctrl        = (word_idx == `IDX_IRQ_CTRL);
  assign sel_hdlc        = (word_idx == `IDX_HDLC_SEL);
  assign sel_loss        = (word_idx == `IDX_LOSS_CTRL);

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the wait cycle; unmapped reads return zero

  always_comb begin
    nxt_readdata = '0;
    case (word_idx)
      `IDX_IRQ_CTRL: begin
        nxt_readdata[`CLR_MODE_BIT] = clr_mode_ff;
        nxt_readdata[`AUTO_CLR_BIT] = auto_clr_ff;
        nxt_readdata[`BLK_EN_BIT]   = blk_en_ff;
      end
      `IDX_HDLC_SEL: begin
        nxt_readdata[`HSEL_MSB:`HSEL_LSB] = hsel_ff;
      end
      `IDX_LOSS_CTRL: begin
        nxt_readdata[`LOSS_OE_BIT] = loss_oe_ff;
      end
      `IDX_IRQ_STATUS: begin
        nxt_readdata[NUM_EVENTS-1:0] = status_vec;
      end
      `IDX_IRQ_ENABLE: begin
        nxt_readdata[NUM_EVENTS-1:0] = enable_vec;
      end
      default: begin
        nxt_readdata = '0;
      end
    endcase
  end

  // loaded only when idle, so data stands through the accept edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readdata_ff    <= '0;
      snap_status_ff <= 1'b0;
    end else if ((bus_state_ff == BUS_IDLE) && avs_read) begin
      readdata_ff    <= nxt_readdata;
      snap_status_ff <= sel_status;
    end
  end

  assign avs_readdata = readdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  // a write with byteenable[0] low completes but stores nothing

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clr_mode_ff <= `IRQ_CTRL_RESET;
      auto_clr_ff <= `IRQ_CTRL_RESET;
      blk_en_ff   <= `IRQ_CTRL_RESET;
    end else if (wr_accept && sel_ctrl) begin
      clr_mode_ff <= avs_writedata[`CLR_MODE_BIT];
      auto_clr_ff <= avs_writedata[`AUTO_CLR_BIT];
      blk_en_ff   <= avs_writedata[`BLK_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hsel_ff <= `HSEL_RESET;
    end else if (wr_accept && sel_hdlc) begin
      hsel_ff <= avs_writedata[`HSEL_MSB:`HSEL_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loss_oe_ff <= `LOSS_OE_RESET;
    end else if (wr_accept && sel_loss) begin
      loss_oe_ff <= avs_writedata[`LOSS_OE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and enable bits

  // only bits the master actually saw as set are cleared by the read
  assign read_snap = (rd_accept && sel_status && snap_status_ff) ?
                     readdata_ff[NUM_EVENTS-1:0] : '0;

  always_comb begin
    status_clr_vec = '0;
    if (clr_mode_ff) begin
      if (wr_accept && sel_status) begin
        status_clr_vec = avs_writedata[NUM_EVENTS-1:0];
      end
    end else begin
      status_clr_vec = read_snap;
    end
  end

  always_comb begin
    enable_clr_vec = '0;
    if (auto_clr_ff) begin
      enable_clr_vec = read_snap;
    end else begin
      enable_clr_vec = '0;
    end
  end

  assign enable_wr = wr_accept & sel_enable;

  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_evt
    irq_event_bit u_bit (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .event_in     (framer_event[i]),
      .status_clr   (status_clr_vec[i]),
      .enable_wr    (enable_wr),
      .enable_wdata (avs_writedata[i]),
      .enable_clr   (enable_clr_vec[i]),
      .status_ff    (status_vec[i]),
      .enable_ff    (enable_vec[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt output
  // registered so the level output never glitches on decode

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= blk_en_ff & (|(status_vec & enable_vec));
    end
  end

  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // hdlc controller routing, one-hot
  // codes 00 and 11 both route to the first controller

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hdlc_sel_ff <= `HSEL_ONEHOT_C1;
    end else begin
      unique case (hsel_ff)
        `HSEL_CODE_C1A,
        `HSEL_CODE_C1B: begin
          hdlc_sel_ff <= `HSEL_ONEHOT_C1;
        end
        `HSEL_CODE_C2: begin
          hdlc_sel_ff <= `HSEL_ONEHOT_C2;
        end
        `HSEL_CODE_C3: begin
          hdlc_sel_ff <= `HSEL_ONEHOT_C3;
        end
      endcase
    end
  end

  assign hdlc_ctrl_sel = hdlc_sel_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // receive loss pin, active low, released when disabled

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loss_pin_n_ff  <= 1'b1;
      loss_pin_oe_ff <= 1'b0;
    end else begin
      loss_pin_n_ff  <= ~(loss_of_signal & loss_oe_ff);
      loss_pin_oe_ff <= loss_oe_ff;
    end
  end

  assign receive_loss_pin_n  = loss_pin_n_ff;
  assign receive_loss_pin_oe = loss_pin_oe_ff;

endmodule : framer_irq_and_link_select_regs

// >>> design/framer_irq_params.svh
`ifndef FRAMER_IRQ_PARAMS_SVH
`define FRAMER_IRQ_PARAMS_SVH

// bus geometry: byte address, register index is address[11:2]
`define ADDR_W            12
`define IDX_W             10
`define DATA_W            32

// register indices, byte address is four times the index
`define IDX_IRQ_CTRL      10'h11B
`define IDX_HDLC_SEL      10'h11D
`define IDX_LOSS_CTRL     10'h11E
`define IDX_IRQ_STATUS    10'h130
`define IDX_IRQ_ENABLE    10'h131

// interrupt_behaviour_control fields
`define CLR_MODE_BIT      2
`define AUTO_CLR_BIT      1
`define BLK_EN_BIT        0
`define IRQ_CTRL_RESET    1'b0

// hdlc_controller_select field and codes
`define HSEL_LSB          0
`define HSEL_MSB          1
`define HSEL_RESET        2'h0
`define HSEL_CODE_C1A     2'h0
`define HSEL_CODE_C2      2'h1
`define HSEL_CODE_C3      2'h2
`define HSEL_CODE_C1B     2'h3
`define HSEL_ONEHOT_C1    3'h1
`define HSEL_ONEHOT_C2    3'h2
`define HSEL_ONEHOT_C3    3'h4

// loss_pin_report_control field
`define LOSS_OE_BIT       6
`define LOSS_OE_RESET     1'b1

// interrupt status / enable reset values
`define IRQ_BIT_RESET     1'b0

`endif

// >>> design/framer_irq_pkg.sv
package framer_irq_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } bus_state_type;

endpackage : framer_irq_pkg

// >>> design/irq_event_bit.sv
`include "framer_irq_params.svh"

module irq_event_bit (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic event_in,
  input  wire logic status_clr,
  input  wire logic enable_wr,
  input  wire logic enable_wdata,
  input  wire logic enable_clr,
  output logic      status_ff,
  output logic      enable_ff
);

  // sticky status: a new event in the clearing cycle survives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= `IRQ_BIT_RESET;
    end else if (event_in) begin
      status_ff <= 1'b1;
    end else if (status_clr) begin
      status_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= `IRQ_BIT_RESET;
    end else if (enable_wr) begin
      enable_ff <= enable_wdata;
    end else if (enable_clr) begin
      enable_ff <= 1'b0;
    end
  end

endmodule : irq_event_bit

// >>> verif/framer_irq_and_link_select_regs_tb_top.sv
`include "framer_irq_params.svh"
module framer_irq_and_link_select_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] A_CTL = {`IDX_IRQ_CTRL, 2'h0};
  localparam logic [11:0] A_SEL = {`IDX_HDLC_SEL, 2'h0};
  localparam logic [11:0] A_LOS = {`IDX_LOSS_CTRL, 2'h0};
  localparam logic [11:0] A_ST  = {`IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_EN  = {`IDX_IRQ_ENABLE, 2'h0};
  logic clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, loss_of_signal = 1'b0;
  logic [11:0] avs_address = 12'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, d;
  logic [3:0]  be = 4'hF;
  logic [7:0]  framer_event = 8'h0, ev;
  logic        avs_waitrequest, irq, receive_loss_pin_n, receive_loss_pin_oe;
  logic [2:0]  hdlc_ctrl_sel;
  int          n_errors = 0;
  int          samples_checked = 0;
  framer_irq_and_link_select_regs #(.NUM_EVENTS(8)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .framer_event(framer_event), .loss_of_signal(loss_of_signal), .irq(irq),
    .hdlc_ctrl_sel(hdlc_ctrl_sel), .receive_loss_pin_n(receive_loss_pin_n),
    .receive_loss_pin_oe(receive_loss_pin_oe));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] hot(input logic [1:0] c);
    return (c == 2'h1) ? 32'h2 : (c == 2'h2) ? 32'h4 : 32'h1;
  endfunction : hot
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic pulse(input logic [7:0] e);
    @(posedge clk_sys);
    framer_event <= e;
    @(posedge clk_sys);
    framer_event <= 8'h0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    #40000;
    n_errors++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hd9f0));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(0, A_CTL, 0); chk(rd, 32'h0);
    bus(0, A_LOS, 0); chk(rd, 32'h40);
    be <= 4'hE;
    bus(1, A_CTL, 32'h7);
    be <= 4'hF;
    bus(0, A_CTL, 0); chk(rd, 32'h0);
    bus(0, 12'h004, 0); chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      d[1:0] = 2'(i);
      bus(1, A_SEL, d);
      repeat (3) @(posedge clk_sys);
      chk(32'(hdlc_ctrl_sel), hot(d[1:0]));
    end
    for (int k = 0; k < 8; k++) begin
      loss_of_signal <= 1'($urandom());
      bus(1, A_LOS, {25'h0, k[0], 6'h0});
      repeat (3) @(posedge clk_sys);
      chk({receive_loss_pin_oe, receive_loss_pin_n}, {k[0], !(k[0] && loss_of_signal)});
    end
    bus(1, A_EN, 32'hFF);
    ev = 8'h1 | 8'($urandom());
    pulse(ev);
    chk(32'(irq), 32'h0);
    bus(1, A_CTL, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    bus(0, A_ST, 0); chk(rd, 32'(ev));
    bus(0, A_ST, 0); chk(rd, 32'h0);
    bus(0, A_EN, 0); chk(rd, 32'hFF);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    bus(1, A_CTL, 32'h3);
    ev = 8'h80 | 8'($urandom());
    pulse(ev);
    bus(0, A_ST, 0); chk(rd, 32'(ev));
    bus(0, A_EN, 0); chk(rd, {24'h0, ~ev});
    bus(1, A_CTL, 32'h5);
    bus(1, A_EN, 32'hFF);
    pulse(ev);
    bus(0, A_ST, 0); chk(rd, 32'(ev));
    bus(0, A_ST, 0); chk(rd, 32'(ev));
    chk(32'(irq), 32'h1);
    bus(1, A_ST, 32'(ev));
    bus(0, A_ST, 0); chk(rd, 32'h0);
    test_done();
  end
endmodule : framer_irq_and_link_select_regs_tb_top

// >>> verif/framer_irq_regs_checker.sv
`include "framer_irq_params.svh"
module framer_irq_regs_checker
  import framer_irq_pkg::*;
#(parameter int NUM_EVENTS = 8) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        loss_of_signal,
  input wire logic        irq,
  input wire logic [2:0]  hdlc_ctrl_sel,
  input wire logic        receive_loss_pin_n,
  input wire logic        receive_loss_pin_oe
);
  logic [9:0] idx;
  logic       wr_ok;
  logic       rd_ok;
  logic [2:0] ctl_ff;
  logic [2:0] sel_ff;
  logic       loe_ff;
  assign idx = avs_address[11:2];
  assign wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign rd_ok = avs_read & ~avs_waitrequest;
  // shadow of the writable control bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl_ff <= 3'h0;
      sel_ff <= 3'h1;
      loe_ff <= 1'b1;
    end else if (wr_ok) begin
      if (idx == `IDX_IRQ_CTRL) ctl_ff <= avs_writedata[2:0];
      if (idx == `IDX_HDLC_SEL) sel_ff <= (avs_writedata[1:0] == 2'h1) ? 3'h2 :
                                          (avs_writedata[1:0] == 2'h2) ? 3'h4 : 3'h1;
      if (idx == `IDX_LOSS_CTRL) loe_ff <= avs_writedata[6];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence wait_s;
    (avs_read | avs_write) && avs_waitrequest;
  endsequence
  sequence acc_s;
    (avs_read | avs_write) && !avs_waitrequest;
  endsequence
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  bus_wait_a: assert property (wait_s |=> !avs_waitrequest)
    else $error("request not accepted after one wait");
  bus_ack_a: assert property (acc_s |=> avs_waitrequest)
    else $error("accept lasted more than one cycle");
  sel_hot_a: assert property ($onehot(hdlc_ctrl_sel))
    else $error("controller select not one-hot");
  sel_follow_a: assert property (wr_ok && idx == `IDX_HDLC_SEL
      |-> ##2 hdlc_ctrl_sel == sel_ff)
    else $error("controller select wrong after write");
  ctrl_read_a: assert property (rd_ok && idx == `IDX_IRQ_CTRL
      |-> avs_readdata == {29'h0, ctl_ff})
    else $error("control register readback wrong");
  irq_gate_a: assert property (irq |-> $past(ctl_ff[`BLK_EN_BIT]))
    else $error("interrupt with block enable off");
  pin_oe_a: assert property (receive_loss_pin_oe |-> $past(loe_ff))
    else $error("loss pin driven while disabled");
  pin_low_a: assert property (!receive_loss_pin_n
      |-> receive_loss_pin_oe && $past(loss_of_signal))
    else $error("loss pin low without cause");
endmodule : framer_irq_regs_checker

bind framer_irq_and_link_select_regs framer_irq_regs_checker #(.NUM_EVENTS(NUM_EVENTS)) chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .loss_of_signal(loss_of_signal), .irq(irq), .hdlc_ctrl_sel(hdlc_ctrl_sel),
  .receive_loss_pin_n(receive_loss_pin_n), .receive_loss_pin_oe(receive_loss_pin_oe));
